// File: tb/mac_tx_framing_and_defer_test.sv
module mac_tx_framing_and_defer_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rst_b = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r, crc, fifoWrData = 0;
  logic fifoWrValid = 0, fifoWrEof = 0, perPacketFcsSuppress = 0, fifoWrReady;
  logic phyTxClock, carrierSenseIn, csOn = 0, txLineActive, serialTxBit, noPre = 0, noFcs = 0;
  logic [2:0] txNibbleUpper;
  logic [7:0] eq[$];
  int bad_count = 0, n_tests = 0, cyc = 0, n, lo[2] = '{1192, 242};
  mtx_top dut (.sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .fifoWrValid, .fifoWrData, .fifoWrEof, .perPacketFcsSuppress, .fifoWrReady,
    .phyTxClock, .carrierSenseIn, .txLineActive, .serialTxBit, .txNibbleUpper);
  mtx_phy_model phy (.phyTxClock, .carrierSenseIn, .csOn, .txLineActive, .serialTxBit);
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // hang guard, well above the roughly 35k cycles the run needs
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 70000) begin
      bad_count++;
      give_verdict;
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] x);
    n_tests++;
    if (g !== x) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  // one apb transfer; pready, data and error are taken at the completing edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  // valid stays up between words; the caller lowers it
  task fw(input logic [31:0] d, input logic eof, input logic np);
    fifoWrValid <= 1'b1;
    fifoWrData <= d;
    fifoWrEof <= eof;
    perPacketFcsSuppress <= np;
    do @(posedge sys_clk); while (fifoWrReady !== 1'b1);
  endtask
  task addByte(input logic [7:0] b, input logic c);
    eq.push_back(b);
    if (c) begin
      crc ^= {24'h0, b};
      repeat (8) crc = crc[0] ? (crc >> 1) ^ 32'hedb88320 : crc >> 1;
    end
  endtask
  // writes a random frame and builds the expected byte stream alongside
  task send(input int nw, input int pinWord, input int pauseAt);
    logic [31:0] w;
    eq.delete();
    phy.bits.delete();
    crc = 32'hffffffff;
    if (!noPre) repeat (7) addByte(8'h55, 1'b0);
    if (!noPre) addByte(8'hd5, 1'b0);
    for (int i = 0; i < nw; i++) begin
      if (i == pauseAt) begin
        fifoWrValid <= 1'b0;
        repeat (200) @(posedge sys_clk);
        chk(txLineActive, 0);
      end
      w = $urandom;
      for (int k = 0; k < 4; k++) addByte(w[8*k +: 8], 1'b1);
      fw(w, i == nw - 1, i == pinWord);
    end
    fifoWrValid <= 1'b0;
    if (!noFcs && pinWord < 0) for (int k = 0; k < 4; k++) addByte(~crc[8*k +: 8], 1'b0);
  endtask
  task checkFrame;
    logic [7:0] b;
    wait (txLineActive === 1'b1);
    wait (txLineActive === 1'b0);
    chk(phy.bits.size(), eq.size() * 8);
    for (int j = 0; j < eq.size() && 8 * j + 7 < phy.bits.size(); j++) begin
      for (int k = 0; k < 8; k++) b[k] = phy.bits[8*j+k];
      chk(b, eq[j]);
    end
    $display("frame of %0d bytes done", eq.size());
  endtask
  initial begin
    void'($urandom(86));
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge sys_clk);
    // reset values, then an unmapped offset
    for (int a = 0; a < 4; a++) begin
      apb(1'b0, 12'(4 * a), 32'h0);
      chk(r, 32'h0);
    end
    apb(1'b0, 12'h020, 32'h0);
    chk(e, 1);
    chk(r, 32'h0);
    $display("register test done");
    // full duplex with a busy medium, threshold of six words
    apb(1'b1, 12'h00c, 32'h2);
    apb(1'b1, 12'h004, 32'h30);
    apb(1'b0, 12'h004, 32'h0);
    chk(r, 32'h30);
    csOn <= 1'b1;
    send(16, -1, 5);
    checkFrame;
    csOn <= 1'b0;
    noPre = 1;
    noFcs = 1;
    apb(1'b1, 12'h000, 32'h14);
    send(16, -1, -1);
    checkFrame;
    noPre = 0;
    noFcs = 0;
    apb(1'b1, 12'h000, 32'h0);
    send(16, 3, -1);
    checkFrame;
    // half duplex: carrier blip in the first, then the second defer period
    apb(1'b1, 12'h00c, 32'h0);
    for (int i = 0; i < 2; i++) begin
      csOn <= 1'b1;
      send(16, -1, -1);
      repeat (200) @(posedge sys_clk);
      chk(txLineActive, 0);
      csOn <= 1'b0;
      repeat (i ? 950 : 400) @(posedge sys_clk);
      csOn <= 1'b1;
      repeat (8) @(posedge sys_clk);
      csOn <= 1'b0;
      n = 0;
      while (txLineActive !== 1'b1) begin
        @(negedge sys_clk);
        n++;
      end
      chk(n >= lo[i] && n < lo[i] + 32, 1);
      checkFrame;
    end
    give_verdict;
  end
endmodule // mac_tx_framing_and_defer_test
bind mtx_top mtx_top_asserts chk_u (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .fifoWrReady(fifoWrReady), .txLineActive(txLineActive));

// File: tb/mtx_phy_model.sv
module mtx_phy_model (
  output logic phyTxClock,
  output logic carrierSenseIn,
  input wire logic csOn,
  input wire logic txLineActive,
  input wire logic serialTxBit
);
  timeunit 1ns;
  timeprecision 1ps;
  logic bits[$];
  // free-running link clock, phase offset so it never lines up with sys_clk
  initial begin
    phyTxClock = 1'b0;
    #13;
    forever #40 phyTxClock = ~phyTxClock;
  end
  assign carrierSenseIn = csOn;
  // mac launches on the falling edge, so the rising edge sits mid-bit
  always @(posedge phyTxClock) if (txLineActive) bits.push_back(serialTxBit);
endmodule // mtx_phy_model

// File: tb/mtx_top_asserts.sv
module mtx_top_asserts (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  input wire logic fifoWrReady,
  input wire logic txLineActive
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] gap;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  // idle cycles since the line dropped, saturating so reset counts as a long gap
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) gap <= 12'hfff;
    else if (txLineActive) gap <= 12'h000;
    else if (gap != 12'hfff) gap <= gap + 12'h001;
  end
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable && pready; endsequence
  property p_answer; s_setup |=> s_access; endproperty
  property p_ready_once; s_access |=> !pready; endproperty
  property p_ready_cause; pready |-> psel && penable; endproperty
  property p_err_pair; pslverr |-> pready && prdata == 32'h0; endproperty
  property p_rd_idle; !pready |-> prdata == 32'h0; endproperty
  property p_fifo_up; $rose(rst_b) |=> fifoWrReady; endproperty
  property p_quiet; $rose(rst_b) |-> !txLineActive ##1 !txLineActive; endproperty
  property p_gap; $rose(txLineActive) |-> gap >= 12'd119; endproperty
  a_answer: assert property (p_answer)
    else $error("no access answer after setup");
  a_ready_once: assert property (p_ready_once)
    else $error("ready held past one cycle");
  a_ready_cause: assert property (p_ready_cause)
    else $error("ready outside an access cycle");
  a_err_pair: assert property (p_err_pair)
    else $error("error without ready or with data");
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero outside access");
  a_fifo_up: assert property (p_fifo_up)
    else $error("fifo not ready after reset");
  a_quiet: assert property (p_quiet)
    else $error("line active straight after reset");
  a_gap: assert property (p_gap)
    else $error("frames closer than the least defer");
endmodule // mtx_top_asserts

// File: verilog/mtx_cfg.svh
`ifndef MTX_CFG_SVH
`define MTX_CFG_SVH

// register byte offsets on the apb bus
`define MTX_OFS_CFG1 12'h000
`define MTX_OFS_CFG3 12'h004
`define MTX_OFS_DEFER 12'h008
`define MTX_OFS_MODE 12'h00c
`define MTX_OFS_STATUS 12'h010

// field positions
`define MTX_CFG1_NO_PRE 2
`define MTX_CFG1_NO_FCS 4
`define MTX_CFG3_THR_HI 7
`define MTX_CFG3_THR_LO 4
`define MTX_MODE_MII 0
`define MTX_MODE_FULL_DUPLEX 1
`define MTX_MODE_SPEED100 2

// reset values
`define MTX_CFG1_RST 8'h00
`define MTX_CFG3_RST 8'h00
`define MTX_DEFER_RST 8'h00
`define MTX_MODE_RST 3'h0

// frame constants
`define MTX_MIN_FRAME_BYTES 64
`define MTX_MAX_FRAME_BYTES 1518
`define MTX_PRE_BYTES 4'd8
`define MTX_PRE_BYTE 8'h55
`define MTX_SFD_BYTE 8'hd5
`define MTX_FCS_BYTES 4'd4
`define MTX_CRC_INIT 32'hffffffff
`define MTX_CRC_POLY 32'hedb88320

// defer timing, times in ns, counts in sys_clk cycles (least times round up)
`define MTX_CLK_PERIOD_NS 8
`define MTX_P1_10M_NS 6400
`define MTX_P1_100M_NS 640
`define MTX_P2_10M_NS 3200
`define MTX_P2_100M_NS 320
`define MTX_NS2CYC(t) (((t) + `MTX_CLK_PERIOD_NS - 1) / `MTX_CLK_PERIOD_NS)
`define MTX_P1_10M_CYC `MTX_NS2CYC(`MTX_P1_10M_NS)
`define MTX_P1_100M_CYC `MTX_NS2CYC(`MTX_P1_100M_NS)
`define MTX_P2_10M_CYC `MTX_NS2CYC(`MTX_P2_10M_NS)
`define MTX_P2_100M_CYC `MTX_NS2CYC(`MTX_P2_100M_NS)
`define MTX_DEFER_STEP_CYC 8

`endif

// File: verilog/mtx_pkg.sv
package mtx_pkg;
  // transmit engine phases, one-hot
  typedef enum logic [4:0] {
    MTX_IDLE = 5'b00001,
    MTX_PRE = 5'b00010,
    MTX_DATA = 5'b00100,
    MTX_FCS = 5'b01000,
    MTX_LAST = 5'b10000
  } mtx_state_t;
  typedef logic [7:0] mtx_byte_t;
endpackage

// File: verilog/mtx_top.sv
// Implementation choices: register access over APB and the register offsets.
`include "mtx_cfg.svh"

// Contract
// - valid frame 64 to 1518 bytes
// - preamble 62 alternating bits then 11
// - six-byte destination and source addresses
// - length/type passes through unchanged
// - payload passes transparently, never altered
// - 32-bit crc over addresses, type, payload
// - crc on the fly; preamble before destination
// - cfg1 bit 2 suppresses generated preamble
// - cfg1 bit 4 suppresses generated fcs
// - pin or bit during write drops fcs
// - start at threshold or end-of-frame
// - threshold cfg3 bits 7:4, default zero
// - threshold words equal twice field value
// - half duplex: defer timed from carrier fall
// - carrier in first period restarts defer
// - carrier in second period is ignored
// - first period programmable, second fixed
// - 10m default defer 9.6 us total
// - 100m default defer 0.96 us total
// - full duplex ignores carrier sense
// - line active with first preamble unit
// - serial falling edge, mii rising edge
module mtx_top #(
  parameter int FIFO_WORDS = 32
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fifoWrValid,
  input wire logic [31:0] fifoWrData,
  input wire logic fifoWrEof,
  input wire logic perPacketFcsSuppress,
  output logic fifoWrReady,
  input wire logic phyTxClock,
  input wire logic carrierSenseIn,
  output logic txLineActive,
  output logic serialTxBit,
  output logic [2:0] txNibbleUpper
);
  import mtx_pkg::*;

  localparam int PW = $clog2(FIFO_WORDS);

  // pointer arithmetic relies on a power-of-two depth
  initial begin
    // the status word keeps only eight bits for the fill level
    if (FIFO_WORDS < 2 || (1 << PW) != FIFO_WORDS || FIFO_WORDS > 128) begin
      $error("mtx_top: FIFO_WORDS must be a power of two from 2 to 128");
    end
  end

  function automatic logic [31:0] crcByte(input logic [31:0] c, input mtx_byte_t d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ `MTX_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // ---------------- registers ----------------
  logic [7:0] cfg1;
  logic [7:0] cfg3;
  logic [7:0] deferReg;
  logic [2:0] modeReg;
  mtx_state_t state;
  logic [PW:0] fifoLevel;

  wire logic cfgNoPre = cfg1[`MTX_CFG1_NO_PRE];
  wire logic cfgNoFcs = cfg1[`MTX_CFG1_NO_FCS];
  wire logic [3:0] thrField = cfg3[`MTX_CFG3_THR_HI:`MTX_CFG3_THR_LO];
  wire logic miiMode = modeReg[`MTX_MODE_MII];
  wire logic fullDuplex = modeReg[`MTX_MODE_FULL_DUPLEX];
  wire logic speed100 = modeReg[`MTX_MODE_SPEED100];

  // apb decode; pready answers in the first access cycle
  wire logic setupPhase = psel & ~penable;
  wire logic accessDone = psel & penable & pready;
  wire logic hitCfg1 = paddr == `MTX_OFS_CFG1;
  wire logic hitCfg3 = paddr == `MTX_OFS_CFG3;
  wire logic hitDefer = paddr == `MTX_OFS_DEFER;
  wire logic hitMode = paddr == `MTX_OFS_MODE;
  wire logic hitStatus = paddr == `MTX_OFS_STATUS;
  wire logic hitAny = hitCfg1 | hitCfg3 | hitDefer | hitMode | hitStatus;
  wire logic [31:0] statusWord = {15'h0000, txLineActive, 3'h0, state,
    {(8 - PW - 1){1'b0}}, fifoLevel};
  wire logic [31:0] readMux = hitCfg1 ? {24'h000000, cfg1} :
                              hitCfg3 ? {24'h000000, cfg3} :
                              hitDefer ? {24'h000000, deferReg} :
                              hitMode ? {29'h00000000, modeReg} :
                              hitStatus ? statusWord : 32'h00000000;

  // read data and answer are captured in the setup cycle
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= setupPhase;
      prdata <= (setupPhase & ~pwrite) ? readMux : 32'h00000000;
      pslverr <= setupPhase & ~hitAny;
    end
  end

  // writes land only at the completing access edge; status is read-only
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg1 <= `MTX_CFG1_RST;
      cfg3 <= `MTX_CFG3_RST;
      deferReg <= `MTX_DEFER_RST;
      modeReg <= `MTX_MODE_RST;
    end else if (accessDone && pwrite) begin
      if (hitCfg1) cfg1 <= pwdata[7:0];
      if (hitCfg3) cfg3 <= pwdata[7:0];
      if (hitDefer) deferReg <= pwdata[7:0];
      if (hitMode) modeReg <= pwdata[2:0];
    end
  end

  // ---------------- transmit fifo ----------------
  // each entry: data, end-of-frame, fcs suppressed
  logic [33:0] fifoMem [FIFO_WORDS];
  logic [PW:0] wrPtr;
  logic [PW:0] rdPtr;
  logic [PW:0] eofCount;
  logic fcsSuppAcc;
  logic fifoPop;

  wire logic fifoPush = fifoWrValid & fifoWrReady;
  wire logic fifoEmpty = fifoLevel == '0;
  wire logic [33:0] headWord = fifoMem[rdPtr[PW-1:0]];
  wire logic suppNow = perPacketFcsSuppress | cfgNoFcs;
  wire logic headEof = headWord[32];
  wire logic [PW:0] next_fifoLevel = fifoLevel + (PW + 1)'(fifoPush) - (PW + 1)'(fifoPop);
  wire logic [PW:0] next_eofCount = eofCount + (PW + 1)'(fifoPush & fifoWrEof)
    - (PW + 1)'(fifoPop & headEof);

  always_ff @(posedge sys_clk) begin
    if (fifoPush) fifoMem[wrPtr[PW-1:0]] <= {fcsSuppAcc | suppNow, fifoWrEof, fifoWrData};
  end

  // suppression seen at any word of the packet sticks to its last word
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr <= '0;
      rdPtr <= '0;
      fifoLevel <= '0;
      eofCount <= '0;
      fcsSuppAcc <= 1'b0;
      fifoWrReady <= 1'b0;
    end else begin
      if (fifoPush) wrPtr <= wrPtr + 1'b1;
      if (fifoPop) rdPtr <= rdPtr + 1'b1;
      fifoLevel <= next_fifoLevel;
      eofCount <= next_eofCount;
      if (fifoPush) fcsSuppAcc <= fifoWrEof ? 1'b0 : (fcsSuppAcc | suppNow);
      fifoWrReady <= next_fifoLevel < (PW + 1)'(FIFO_WORDS);
    end
  end

  // ---------------- link pin synchronisers ----------------
  logic [2:0] clkSync;
  logic [1:0] csSync;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      clkSync <= 3'h0;
      csSync <= 2'h0;
    end else begin
      clkSync <= {clkSync[1:0], phyTxClock};
      csSync <= {csSync[0], carrierSenseIn};
    end
  end

  // serial mode moves on the falling edge, mii on the rising edge
  wire logic clkRise = clkSync[1] & ~clkSync[2];
  wire logic clkFall = ~clkSync[1] & clkSync[2];
  wire logic linkTick = miiMode ? clkRise : clkFall;
  wire logic carrier = csSync[1];

  // ---------------- defer timer ----------------
  logic [15:0] deferCnt;
  logic csIgnored;

  wire logic [15:0] p1Cyc = (speed100 ? 16'(`MTX_P1_100M_CYC) : 16'(`MTX_P1_10M_CYC))
    + 16'(deferReg) * 16'(`MTX_DEFER_STEP_CYC);
  wire logic [15:0] p2Cyc = speed100 ? 16'(`MTX_P2_100M_CYC) : 16'(`MTX_P2_10M_CYC);
  wire logic [15:0] totalCyc = p1Cyc + p2Cyc;
  wire logic csSeen = carrier & ~fullDuplex;
  wire logic inFirst = deferCnt < p1Cyc;
  wire logic deferDone = deferCnt >= totalCyc;

  // the counter restarts from the end of own transmission or of carrier
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      deferCnt <= 16'h0000;
      csIgnored <= 1'b0;
    end else if (txLineActive) begin
      deferCnt <= 16'h0000;
      csIgnored <= 1'b0;
    end else if (csSeen && (inFirst || (deferDone && !csIgnored))) begin
      deferCnt <= 16'h0000;
      csIgnored <= 1'b0;
    end else begin
      if (csSeen) csIgnored <= 1'b1;
      if (!deferDone) deferCnt <= deferCnt + 16'h0001;
    end
  end

  // ---------------- transmit engine ----------------
  logic [3:0] byteIdx;
  logic [3:0] unitsLeft;
  mtx_byte_t shiftByte;
  logic [31:0] crc;
  logic frameNoFcs;

  // start needs threshold or a whole frame queued, and a met defer
  wire logic [PW:0] thrWords = (PW + 1)'({thrField, 1'b0});
  wire logic thrMet = !fifoEmpty && fifoLevel >= thrWords;
  wire logic startOk = (thrMet || eofCount != '0) && deferDone;
  wire logic needByte = unitsLeft == 4'h0;
  wire logic [3:0] unitsPerByte = miiMode ? 4'h2 : 4'h8;
  wire mtx_byte_t dataByte = headWord[{byteIdx[1:0], 3'b000} +: 8];
  wire mtx_byte_t preByte = (byteIdx == `MTX_PRE_BYTES - 4'h1) ? `MTX_SFD_BYTE : `MTX_PRE_BYTE;
  wire mtx_byte_t fcsByte = ~crc[{byteIdx[1:0], 3'b000} +: 8];
  wire logic startNow = state == MTX_IDLE && startOk;
  wire logic dataPhase = state == MTX_DATA || (startNow && cfgNoPre);
  wire logic underflow = dataPhase && needByte && fifoEmpty;
  wire mtx_byte_t nextByte = (state == MTX_PRE || (startNow && !cfgNoPre)) ? preByte :
                             (state == MTX_FCS) ? fcsByte : dataByte;
  wire mtx_byte_t curByte = needByte ? nextByte : shiftByte;
  wire logic wordEnd = byteIdx[1:0] == 2'h3;
  wire logic noFcsHere = headWord[33] | cfgNoFcs;

  assign fifoPop = linkTick && dataPhase && needByte && !fifoEmpty && wordEnd;

  // one unit per link tick; a byte is fetched when the previous one is spent
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= MTX_IDLE;
      byteIdx <= 4'h0;
      unitsLeft <= 4'h0;
      shiftByte <= 8'h00;
      crc <= `MTX_CRC_INIT;
      frameNoFcs <= 1'b0;
      txLineActive <= 1'b0;
      serialTxBit <= 1'b0;
      txNibbleUpper <= 3'h0;
    end else if (linkTick) begin
      if ((state == MTX_IDLE && !startOk) || underflow ||
          (state == MTX_LAST && needByte)) begin
        // drop the line after the final unit, or abandon a starved frame
        state <= MTX_IDLE;
        txLineActive <= 1'b0;
        serialTxBit <= 1'b0;
        txNibbleUpper <= 3'h0;
        unitsLeft <= 4'h0;
        byteIdx <= 4'h0;
      end else begin
        txLineActive <= 1'b1;
        serialTxBit <= curByte[0];
        txNibbleUpper <= miiMode ? curByte[3:1] : 3'h0;
        shiftByte <= miiMode ? {4'h0, curByte[7:4]} : {1'b0, curByte[7:1]};
        unitsLeft <= (needByte ? unitsPerByte : unitsLeft) - 4'h1;
        if (needByte) begin
          byteIdx <= byteIdx + 4'h1;
          case (state)
            MTX_IDLE: begin
              crc <= cfgNoPre ? crcByte(`MTX_CRC_INIT, dataByte) : `MTX_CRC_INIT;
              state <= cfgNoPre ? MTX_DATA : MTX_PRE;
              byteIdx <= 4'h1;
            end
            MTX_PRE: begin
              // destination address follows the delimiter directly
              if (byteIdx == `MTX_PRE_BYTES - 4'h1) begin
                state <= MTX_DATA;
                byteIdx <= 4'h0;
              end
            end
            MTX_DATA: begin
              crc <= crcByte(crc, dataByte);
              if (wordEnd && headEof) begin
                frameNoFcs <= noFcsHere;
                state <= noFcsHere ? MTX_LAST : MTX_FCS;
                byteIdx <= 4'h0;
              end
            end
            MTX_FCS: begin
              // fcs bytes follow the last data byte with no gap
              if (byteIdx == `MTX_FCS_BYTES - 4'h1) state <= MTX_LAST;
            end
            default: state <= MTX_IDLE;
          endcase
        end
      end
    end
  end

  // frame length limits are the host's data; the engine neither pads nor cuts
  // note: a start from idle with the preamble suppressed also sends and checksums the first data byte
endmodule // mtx_top
